//--- ktc_pkg.sv
// Purpose: Constants for the link training control register bank
// Assumes: Word addressed register port, 8-bit address
// Notes:   Field positions and reset values live here; the checks in ktc_regs and the bench repeat some as literals
package ktc_pkg;
  // ----------------------------------------
  // Register word addresses
  // ----------------------------------------
  localparam logic [7:0] OFF_MAIN = 8'hd0;
  localparam logic [7:0] OFF_CMD  = 8'hd1;
  localparam logic [7:0] OFF_STAT = 8'hd2;
  localparam logic [7:0] OFF_BER  = 8'hd3;
  localparam logic [7:0] OFF_COEF = 8'hd4;
  // ----------------------------------------
  // Main control word fields
  // ----------------------------------------
  localparam int B_TRAIN_EN   = 0;
  localparam int B_PART_OVR   = 16;
  localparam int B_LCL_OVR    = 17;
  localparam int B_RSV_LO     = 18;
  localparam int B_RSV_HI     = 19;
  localparam int B_CTLE_LO    = 20;
  localparam int B_SWING      = 23;
  localparam int B_DFE_LO     = 24;
  localparam int B_PEAK       = 28;
  localparam int B_PSTEP_LO   = 29;
  localparam int ALGO_LO      = 1;
  localparam logic [31:0] MAIN_RST = 32'h0002_2129;
  localparam logic [2:0] CTLE_TUNE = 3'h3;
  localparam logic [2:0] DFE_END   = 3'h2;
  localparam logic [2:0] DFE_STEP  = 3'h3;
  // ----------------------------------------
  // Command strobes and coefficient value
  // ----------------------------------------
  localparam int B_RESTART    = 0;
  localparam int B_PART_UPD   = 4;
  localparam int B_LCL_UPD    = 8;
  localparam int PART_VAL_LO  = 0;
  localparam int LCL_VAL_LO   = 16;
  localparam logic [31:0] COEF_RST = 32'h0000_0000;
  // ----------------------------------------
  // Error window timing fields
  // ----------------------------------------
  localparam int BER_F_LO     = 0;
  localparam int BER_K_LO     = 10;
  localparam int BER_M_LO     = 20;
  localparam logic [9:0] BER_F_RST = 10'h000;
  localparam logic [9:0] BER_K_RST = 10'h000;
  localparam logic [9:0] BER_M_RST = 10'h000;
  // Strobe slots
  localparam int N_STB  = 3;
  localparam int S_RST  = 0;
  localparam int S_PART = 1;
  localparam int S_LCL  = 2;
endpackage

//--- ktc_cmd_if.sv
// Purpose: Command strobe path between register bank and strobe unit
// Assumes: Single clock domain
// Notes:   Requests are one-cycle write decodes
`timescale 1ns/1ps
interface ktc_cmd_if;
  logic [2:0] req;
  logic [2:0] allow;
  logic [2:0] pulse;
  modport bank (output req, output allow, input pulse);
  modport gen  (input req, input allow, output pulse);
endinterface

//--- ktc_strobe_gen.sv
// Purpose: Self-clearing command pulses
// Assumes: Requests last one cycle
// Notes:   A request without its override enable is dropped
`timescale 1ns/1ps
module ktc_strobe_gen (
  input  wire logic core_clk,
  input  wire logic nrst,
  ktc_cmd_if.gen    cmd
);
  genvar i;
  generate
    for (i = 0; i < ktc_pkg::N_STB; i++) begin : g_stb
      logic pulse_q;
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          pulse_q <= 1'b0;
        end else begin
          pulse_q <= cmd.req[i] & cmd.allow[i];
        end
      end
      assign cmd.pulse[i] = pulse_q;
    end
  endgenerate
endmodule

//--- ktc_regs.sv
// Purpose: Link training control and status registers
// Assumes: Engine status inputs synchronous to core_clk
// Notes:   Read data valid the cycle after the read strobe
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module ktc_regs (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        rx_trained,
  input  wire logic        frame_lock,
  input  wire logic        startup_busy,
  input  wire logic        train_fail,
  input  wire logic        train_err,
  input  wire logic        lock_err,
  input  wire logic        ctle_lock_loss,
  input  wire logic        ctle_tune_err,
  output logic             training_enable,
  output logic [14:0]      algo_cfg,
  output logic             partner_coef_override,
  output logic             local_coef_override,
  output logic             ctle_tune_en,
  output logic             dfe_end_en,
  output logic             dfe_step_en,
  output logic             high_swing_en,
  output logic             peak_mode_en,
  output logic [2:0]       peak_post_step,
  output logic             training_restart,
  output logic             partner_coef_send,
  output logic [7:0]       partner_coef_val,
  output logic             local_coef_load,
  output logic [7:0]       local_coef_val,
  output logic [9:0]       ber_frames,
  output logic [9:0]       ber_kframes,
  output logic [9:0]       ber_mframes,
  output logic             ber_frames_active
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic hit(
    input logic [7:0] a,
    input logic [7:0] off
  );
    hit = (a == off);
  endfunction

  logic        wr_main;
  logic        wr_cmd;
  logic        wr_ber;
  logic        wr_coef;
  logic [31:0] main_q;
  logic [31:0] coef_q;
  logic [29:0] ber_q;
  logic [7:0]  stat_w;
  logic [31:0] rd_d;
  logic [31:0] rdata_q;
  logic [2:0]  ctle_sel;
  logic [2:0]  dfe_sel;

  assign wr_main = reg_wr & hit(reg_addr, ktc_pkg::OFF_MAIN);
  assign wr_cmd  = reg_wr & hit(reg_addr, ktc_pkg::OFF_CMD);
  assign wr_ber  = reg_wr & hit(reg_addr, ktc_pkg::OFF_BER);
  assign wr_coef = reg_wr & hit(reg_addr, ktc_pkg::OFF_COEF);

  // ----------------------------------------
  // Main control word
  // ----------------------------------------
  // local override resets set
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      main_q <= ktc_pkg::MAIN_RST;
    end else if (wr_main) begin
      // Reserved bits stored as written; software does the RMW
      main_q <= reg_wdata;
    end
  end

  assign training_enable       = main_q[ktc_pkg::B_TRAIN_EN];
  assign algo_cfg              = main_q[ktc_pkg::ALGO_LO +: 15];
  // engine owns partner requests when clear
  assign partner_coef_override = main_q[ktc_pkg::B_PART_OVR];
  assign local_coef_override   = main_q[ktc_pkg::B_LCL_OVR];
  assign ctle_sel              = main_q[ktc_pkg::B_CTLE_LO +: 3];
  assign dfe_sel               = main_q[ktc_pkg::B_DFE_LO +: 3];
  assign ctle_tune_en          = (ctle_sel == ktc_pkg::CTLE_TUNE);
  assign dfe_end_en            = (dfe_sel == ktc_pkg::DFE_END);
  assign dfe_step_en           = (dfe_sel == ktc_pkg::DFE_STEP);
  assign high_swing_en         = main_q[ktc_pkg::B_SWING];
  assign peak_mode_en          = main_q[ktc_pkg::B_PEAK];
  assign peak_post_step        = main_q[ktc_pkg::B_PSTEP_LO +: 3];

  // ----------------------------------------
  // Coefficient values and error window
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      coef_q <= ktc_pkg::COEF_RST;
    end else if (wr_coef) begin
      coef_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ber_q <= {ktc_pkg::BER_M_RST, ktc_pkg::BER_K_RST, ktc_pkg::BER_F_RST};
    end else if (wr_ber) begin
      ber_q <= reg_wdata[29:0];
    end
  end

  assign partner_coef_val = coef_q[ktc_pkg::PART_VAL_LO +: 8];
  assign local_coef_val   = coef_q[ktc_pkg::LCL_VAL_LO +: 8];
  assign ber_frames       = ber_q[ktc_pkg::BER_F_LO +: 10];
  assign ber_kframes      = ber_q[ktc_pkg::BER_K_LO +: 10];
  assign ber_mframes      = ber_q[ktc_pkg::BER_M_LO +: 10];
  // frame count only without kilo count
  assign ber_frames_active = (ber_kframes == 10'h000);

  // ----------------------------------------
  // Command strobes
  // ----------------------------------------
  ktc_cmd_if cmd ();

  assign cmd.req[ktc_pkg::S_RST]    = wr_cmd & reg_wdata[ktc_pkg::B_RESTART];
  assign cmd.req[ktc_pkg::S_PART]   = wr_cmd & reg_wdata[ktc_pkg::B_PART_UPD];
  assign cmd.req[ktc_pkg::S_LCL]    = wr_cmd & reg_wdata[ktc_pkg::B_LCL_UPD];
  // Overrides are taken at the strobe's write edge; enabling them in the same cycle is too late
  assign cmd.allow[ktc_pkg::S_RST]  = 1'b1;
  assign cmd.allow[ktc_pkg::S_PART] = partner_coef_override;
  assign cmd.allow[ktc_pkg::S_LCL]  = local_coef_override;

  ktc_strobe_gen u_stb (
    .core_clk (core_clk),
    .nrst     (nrst),
    .cmd      (cmd.gen)
  );

  assign training_restart  = cmd.pulse[ktc_pkg::S_RST];
  assign partner_coef_send = cmd.pulse[ktc_pkg::S_PART];
  assign local_coef_load   = cmd.pulse[ktc_pkg::S_LCL];

  // ----------------------------------------
  // Status and read path
  // ----------------------------------------
  // live flags
  assign stat_w = {ctle_tune_err, ctle_lock_loss, lock_err, train_err,
                   train_fail, startup_busy, frame_lock, rx_trained};

  always_comb begin
    rd_d = 32'h0000_0000;
    case (reg_addr)
      ktc_pkg::OFF_MAIN: begin
        rd_d = main_q;
      end
      ktc_pkg::OFF_STAT: begin
        rd_d = {24'h00_0000, stat_w};
      end
      ktc_pkg::OFF_BER: begin
        rd_d = {2'h0, ber_q};
      end
      ktc_pkg::OFF_COEF: begin
        rd_d = coef_q;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // Data held only for the cycle after the read; zero otherwise
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_reset_defaults: assert property (
    $rose(nrst) |-> training_enable && local_coef_override
      && !high_swing_en && !ctle_tune_en && !dfe_end_en && !dfe_step_en)
    else $error("control defaults wrong after reset");

  // Back to back strobe writes give back to back pulses; the drop is checked separately
  a_restart_pulse: assert property (
    wr_cmd && reg_wdata[ktc_pkg::B_RESTART] |=> training_restart)
    else $error("restart pulse missing after write");

  a_restart_free: assert property (
    wr_cmd && reg_wdata[ktc_pkg::B_RESTART] && !training_enable
      |=> training_restart)
    else $error("restart gated by protocol enable");

  a_restart_idle: assert property (
    !(wr_cmd && reg_wdata[ktc_pkg::B_RESTART]) |=> !training_restart)
    else $error("restart pulse without write");

  a_partner_send: assert property (
    wr_cmd && reg_wdata[ktc_pkg::B_PART_UPD]
      |=> partner_coef_send == $past(partner_coef_override))
    else $error("partner send not gated by override");

  a_local_load: assert property (
    wr_cmd && reg_wdata[ktc_pkg::B_LCL_UPD] && local_coef_override
      |=> local_coef_load)
    else $error("local load pulse wrong");

  a_ctle_mode: assert property (
    wr_main |=> ctle_tune_en
      == ($past(reg_wdata[22:20]) == ktc_pkg::CTLE_TUNE))
    else $error("ctle tuning decode wrong");

  a_dfe_mode: assert property (
    wr_main |=> (dfe_end_en == ($past(reg_wdata[26:24]) == ktc_pkg::DFE_END))
      && (dfe_step_en == ($past(reg_wdata[26:24]) == ktc_pkg::DFE_STEP)))
    else $error("dfe decode wrong");

  a_peak_fields: assert property (
    wr_main |=> peak_post_step == $past(reg_wdata[31:29])
      && peak_mode_en == $past(reg_wdata[28]))
    else $error("peak fields not stored");

  a_status_read: assert property (
    reg_rd && reg_addr == ktc_pkg::OFF_STAT
      |=> reg_rdata == {24'h00_0000, $past(stat_w)})
    else $error("status read mismatch");

  a_cmd_reads_zero: assert property (
    reg_rd && reg_addr == ktc_pkg::OFF_CMD |=> reg_rdata == 32'h0000_0000)
    else $error("strobe register read nonzero");

  a_ber_window: assert property (
    wr_ber |=> ber_frames_active == ($past(reg_wdata[19:10]) == 10'h000))
    else $error("frame window select wrong");

  // Pulses drop unless a new strobe write arrives
  a_partner_idle: assert property (
    !(wr_cmd && reg_wdata[ktc_pkg::B_PART_UPD]) |=> !partner_coef_send)
    else $error("partner send without write");

  a_local_idle: assert property (
    !(wr_cmd && reg_wdata[ktc_pkg::B_LCL_UPD]) |=> !local_coef_load)
    else $error("local load without write");

  a_local_gated: assert property (
    wr_cmd && reg_wdata[ktc_pkg::B_LCL_UPD] && !local_coef_override
      |=> !local_coef_load)
    else $error("local load fired without override");

  a_override_bits: assert property (
    wr_main |=> partner_coef_override == $past(reg_wdata[ktc_pkg::B_PART_OVR])
      && local_coef_override == $past(reg_wdata[ktc_pkg::B_LCL_OVR]))
    else $error("override bits not stored");

  a_swing_bit: assert property (
    wr_main |=> high_swing_en == $past(reg_wdata[ktc_pkg::B_SWING]))
    else $error("swing bit not stored");

  a_enable_bit: assert property (
    wr_main |=> training_enable == $past(reg_wdata[ktc_pkg::B_TRAIN_EN]))
    else $error("enable bit not stored");

  a_coef_fields: assert property (
    wr_coef |=> partner_coef_val == $past(reg_wdata[ktc_pkg::PART_VAL_LO +: 8])
      && local_coef_val == $past(reg_wdata[ktc_pkg::LCL_VAL_LO +: 8]))
    else $error("coefficient bytes not stored");

  a_ber_frames: assert property (
    wr_ber |=> ber_frames == $past(reg_wdata[ktc_pkg::BER_F_LO +: 10])
      && ber_kframes == $past(reg_wdata[ktc_pkg::BER_K_LO +: 10]))
    else $error("frame window counts not stored");

  // Reads and status writes must never disturb the control word
  a_main_hold: assert property (
    !wr_main |=> main_q == $past(main_q))
    else $error("control word changed without write");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  c_partner_send: cover property (
    wr_cmd && reg_wdata[ktc_pkg::B_PART_UPD] && partner_coef_override ##1 partner_coef_send);
  c_local_load: cover property (
    wr_cmd && reg_wdata[ktc_pkg::B_LCL_UPD] && local_coef_override ##1 local_coef_load);
  c_restart: cover property (training_restart);
  c_status_read: cover property (reg_rd && reg_addr == ktc_pkg::OFF_STAT
    && rx_trained);
  c_b2b_write_read: cover property (wr_coef ##1 reg_rd);
endmodule

//--- ktc_regs_tb_top.sv
// Purpose: Self-checking bench for the link training register bank
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Reads and strobe pulses are checked from expectation queues
`timescale 1ns/1ps
module ktc_regs_tb_top;
  logic        core_clk;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0]  st;
  logic        training_enable, partner_coef_override, local_coef_override, ctle_tune_en;
  logic        dfe_end_en, dfe_step_en, high_swing_en, peak_mode_en, ber_frames_active;
  logic        training_restart, partner_coef_send, local_coef_load;
  logic [14:0] algo_cfg;
  logic [2:0]  peak_post_step;
  logic [7:0]  partner_coef_val, local_coef_val;
  logic [9:0]  ber_frames, ber_kframes, ber_mframes;
  logic [31:0] main_m, coef_m, e_rd, w;
  logic [29:0] ber_m;
  logic [2:0]  e_pl;
  logic        rd_p, pl_p;
  logic [31:0] rd_q [$];
  logic [2:0]  pl_q [$];
  int          failures, checks, cyc;
  logic [7:0]  addrs [8] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'h00, 8'hd5, 8'hcf};

  ktc_regs i_ktc_regs (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_trained(st[0]), .frame_lock(st[1]),
    .startup_busy(st[2]), .train_fail(st[3]), .train_err(st[4]), .lock_err(st[5]),
    .ctle_lock_loss(st[6]), .ctle_tune_err(st[7]), .training_enable(training_enable), .algo_cfg(algo_cfg),
    .partner_coef_override(partner_coef_override), .local_coef_override(local_coef_override),
    .ctle_tune_en(ctle_tune_en), .dfe_end_en(dfe_end_en), .dfe_step_en(dfe_step_en),
    .high_swing_en(high_swing_en), .peak_mode_en(peak_mode_en), .peak_post_step(peak_post_step),
    .training_restart(training_restart), .partner_coef_send(partner_coef_send),
    .partner_coef_val(partner_coef_val), .local_coef_load(local_coef_load), .local_coef_val(local_coef_val),
    .ber_frames(ber_frames), .ber_kframes(ber_kframes), .ber_mframes(ber_mframes),
    .ber_frames_active(ber_frames_active));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    chk("reg_rdata", e, g);
  endtask

  task automatic chk_pl(input logic [2:0] e, input logic [2:0] g);
    chk("strobes", 32'(e), 32'(g));
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Register port driver
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    case (a)
      8'hd0:   main_m = d;
      8'hd3:   ber_m = d[29:0];
      8'hd4:   coef_m = d;
      8'hd1:   pl_q.push_back({d[0], d[4] & main_m[16], d[8] & main_m[17]});
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a);
    logic [7:0] s;
    s = 8'($urandom);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    st       <= s;
    case (a)
      8'hd0:   rd_q.push_back(main_m);
      8'hd2:   rd_q.push_back({24'h0, s});
      8'hd3:   rd_q.push_back({2'h0, ber_m});
      8'hd4:   rd_q.push_back(coef_m);
      default: rd_q.push_back(32'h0);
    endcase
  endtask

  task automatic idle();
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // Config levels settle one edge after the idle cycle
  task automatic cfg();
    @(posedge core_clk);
    chk("training_enable", 32'(main_m[0]), 32'(training_enable));
    chk("algo_cfg", 32'(main_m[15:1]), 32'(algo_cfg));
    chk("partner_coef_override", 32'(main_m[16]), 32'(partner_coef_override));
    chk("local_coef_override", 32'(main_m[17]), 32'(local_coef_override));
    chk("ctle_tune_en", 32'(main_m[22:20] == 3'h3), 32'(ctle_tune_en));
    chk("high_swing_en", 32'(main_m[23]), 32'(high_swing_en));
    chk("dfe_end_en", 32'(main_m[26:24] == 3'h2), 32'(dfe_end_en));
    chk("dfe_step_en", 32'(main_m[26:24] == 3'h3), 32'(dfe_step_en));
    chk("peak_mode_en", 32'(main_m[28]), 32'(peak_mode_en));
    chk("peak_post_step", 32'(main_m[31:29]), 32'(peak_post_step));
    chk("partner_coef_val", 32'(coef_m[7:0]), 32'(partner_coef_val));
    chk("local_coef_val", 32'(coef_m[23:16]), 32'(local_coef_val));
    chk("ber_frames", 32'(ber_m[9:0]), 32'(ber_frames));
    chk("ber_kframes", 32'(ber_m[19:10]), 32'(ber_kframes));
    chk("ber_mframes", 32'(ber_m[29:20]), 32'(ber_mframes));
    chk("ber_frames_active", 32'(ber_m[19:10] == 10'h000), 32'(ber_frames_active));
  endtask

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      rd_p <= 1'b0;
      pl_p <= 1'b0;
    end else begin
      e_rd = rd_p ? rd_q.pop_front() : 32'h0;
      e_pl = pl_p ? pl_q.pop_front() : 3'h0;
      chk_rd(e_rd, reg_rdata);
      chk_pl(e_pl, {training_restart, partner_coef_send, local_coef_load});
      rd_p <= reg_rd;
      pl_p <= reg_wr && reg_addr == 8'hd1;
    end
  end

  // Hang guard far above the roughly 170 cycles of stimulus
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst      = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    st        = 8'h00;
    main_m    = ktc_pkg::MAIN_RST;
    coef_m    = 32'h0;
    ber_m     = 30'h0;
    failures  = 0;
    checks    = 0;
    cyc       = 0;
    void'($urandom(11275));
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    cfg();
    foreach (addrs[i]) rd(addrs[i]);
    idle();
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      w[22:20] = 3'(i);
      w[26:24] = 3'(7 - i);
      wr(8'hd0, w);
      wr(8'hd2, $urandom);
      wr(8'hd5, $urandom);
      rd(8'hd0);
      idle();
      cfg();
    end
    // frame window with and without kilo field
    for (int i = 0; i < 6; i++) begin
      wr(8'hd4, $urandom);
      w = $urandom;
      if (i[0]) begin
        w[19:10] = 10'h000;
      end
      wr(8'hd3, w);
      rd(8'hd3);
      rd(8'hd4);
      idle();
      cfg();
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'hd0, {main_m[31:18], 2'(i), main_m[15:0]});
      wr(8'hd1, 32'h0000_0111);
      wr(8'hd1, 32'h0000_0111);
      wr(8'hd1, 32'h0);
      wr(8'hd1, $urandom);
      rd(8'hd1);
      idle();
    end
    // defaults come back after a mid-run reset
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    main_m = ktc_pkg::MAIN_RST;
    coef_m = 32'h0;
    ber_m  = 30'h0;
    cfg();
    rd(8'hd0);
    rd(8'hd4);
    rd(8'hd3);
    idle();
    repeat (24) rd(8'hd2);
    idle();
    repeat (2) @(posedge core_clk);
    summarize();
  end
endmodule
